// [sim/testbench.sv]
// self-checking bench for the conditional branch unit
`timescale 1ns/100ps
module testbench;
    logic                       core_clk;
    logic                       rst_b;
    cbu_pkg::cbu_req_t          req;
    logic [7:0]                 flags_out;
    logic [cbu_pkg::PC_W-1:0]   pc;
    logic                       busy;
    logic                       done;
    logic                       taken;
    int                         error_cnt;
    int                         compares;
    logic [15:0]                exp_pc;

    cbu_top i_cbu_top
    (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .req       (req),
        .flags_out (flags_out),
        .pc        (pc),
        .busy      (busy),
        .done      (done),
        .taken     (taken)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // expected condition per operation
    function automatic logic cond(cbu_pkg::cbu_op_t op, logic [7:0] f);
        case (op)
            cbu_pkg::branch_if_not_equal:       cond = ~f[1];
            cbu_pkg::branch_on_carry_high:      cond = f[0];
            cbu_pkg::branch_unsigned_below:     cond = f[0];
            cbu_pkg::branch_on_carry_low:       cond = ~f[0];
            cbu_pkg::branch_unsigned_not_below: cond = ~f[0];
            cbu_pkg::branch_if_negative:        cond = f[2];
            cbu_pkg::branch_if_positive:        cond = ~f[2];
            cbu_pkg::branch_signed_not_less:    cond = ~(f[2] ^ f[3]);
            cbu_pkg::branch_signed_less:        cond = f[2] ^ f[3];
            cbu_pkg::branch_nibble_carry_high:  cond = f[5];
            cbu_pkg::branch_nibble_carry_low:   cond = ~f[5];
            cbu_pkg::branch_user_flag_high:     cond = f[6];
            default:                            cond = 1'b0;
        endcase
    endfunction

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // one branch; hold keeps valid up through the busy cycle
    task automatic run_br(input cbu_pkg::cbu_op_t op, input logic [6:0] o,
                          input logic [7:0] f, input bit hold);
        logic t;
        t = cond(op, f);
        @(posedge core_clk);
        req <= {1'b1, op, o, f};
        @(posedge core_clk);
        if (!hold)
            req.valid <= 1'b0;
        exp_pc = t ? exp_pc + {{9{o[6]}}, o} + 16'h0001 : exp_pc + 16'h0001;
        #1;
        chk("pc", exp_pc, pc);
        chk("taken", {15'h0, t}, {15'h0, taken});
        chk("busy", {15'h0, t}, {15'h0, busy});
        chk("done", {15'h0, ~t}, {15'h0, done});
        chk("flags_out", {8'h00, f}, {8'h00, flags_out});
        if (t)
        begin
            @(posedge core_clk);
            req.valid <= 1'b0;
            #1;
            chk("busy", 16'h0000, {15'h0, busy});
            chk("done", 16'h0001, {15'h0, done});
            chk("pc", exp_pc, pc);
        end
        @(posedge core_clk);
        #1;
        chk("done", 16'h0000, {15'h0, done});
    endtask

    task automatic t_reset;
        #1;
        chk("pc", 16'h0000, pc);
        chk("status", 16'h0000, {8'h00, flags_out | {busy, done, taken}});
        $display("test reset done");
    endtask

    task automatic t_sweep;
        logic [7:0] fw [3];
        logic [6:0] ow [3];
        fw = '{8'h00, 8'hFF, 8'h04};
        ow = '{7'h3F, 7'h40, 7'h7F};
        for (int i = 0; i < 12; i++)
            for (int k = 0; k < 3; k++)
                run_br(cbu_pkg::cbu_op_t'(i), ow[k], fw[k], k == 1 &&
                       cond(cbu_pkg::cbu_op_t'(i), fw[k]));
        $display("test sweep done");
    endtask

    task automatic t_b2b;
        @(posedge core_clk);
        req <= {1'b1, cbu_pkg::branch_on_carry_high, 7'h05, 8'h00};
        @(posedge core_clk);
        req <= {1'b1, cbu_pkg::branch_if_positive, 7'h05, 8'h04};
        #1;
        chk("pc", exp_pc + 16'h0001, pc);
        @(posedge core_clk);
        req.valid <= 1'b0;
        #1;
        chk("pc", exp_pc + 16'h0002, pc);
        chk("done", 16'h0001, {15'h0, done});
        exp_pc = exp_pc + 16'h0002;
        @(posedge core_clk);
        $display("test back_to_back done");
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #8000;
        error_cnt++;
        $display("BAD watchdog expected finish seen timeout");
        complete_run;
    end

    initial
    begin
        error_cnt = 0;
        compares = 0;
        exp_pc = 16'h0000;
        rst_b = 1'b0;
        req = '0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset;
        t_sweep;
        t_b2b;
        complete_run;
    end
endmodule

// [verilog/cbu_cond.sv]
// condition evaluation for one branch operation
`timescale 1ns/100ps
module cbu_cond
(
    // request
    input  wire cbu_pkg::cbu_op_t op,
    input  wire logic [7:0]       flags,
    // result
    output logic                  hit
);

    logic c;
    logic z;
    logic n;
    logic v;
    logic h;
    logic t;

    assign c = flags[cbu_pkg::FLG_C];
    assign z = flags[cbu_pkg::FLG_Z];
    assign n = flags[cbu_pkg::FLG_N];
    assign v = flags[cbu_pkg::FLG_V];
    assign h = flags[cbu_pkg::FLG_H];
    assign t = flags[cbu_pkg::FLG_T];

    always_comb
    begin
        case (op)
            cbu_pkg::branch_if_not_equal:       hit = !z;
            cbu_pkg::branch_on_carry_high:      hit = c;
            cbu_pkg::branch_unsigned_below:     hit = c;
            cbu_pkg::branch_on_carry_low:       hit = !c;
            cbu_pkg::branch_unsigned_not_below: hit = !c;
            cbu_pkg::branch_if_negative:        hit = n;
            cbu_pkg::branch_if_positive:        hit = !n;
            cbu_pkg::branch_signed_not_less:    hit = !(n ^ v);
            cbu_pkg::branch_signed_less:        hit = n ^ v;
            cbu_pkg::branch_nibble_carry_high:  hit = h;
            cbu_pkg::branch_nibble_carry_low:   hit = !h;
            cbu_pkg::branch_user_flag_high:     hit = t;
            default:                            hit = 1'b0;
        endcase
    end

endmodule

// [verilog/cbu_pkg.sv]
// shared types and constants for the conditional branch unit
package cbu_pkg;

    localparam int PC_W  = 16;
    localparam int OFS_W = 7;

    localparam logic [PC_W-1:0] PC_RST   = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP  = 16'h0001;
    localparam logic [7:0]      FLG_RST  = 8'h00;

    // status flag positions in the flag word
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;

    typedef enum logic [3:0] {
        branch_if_not_equal       = 4'h0,
        branch_on_carry_high      = 4'h1,
        branch_on_carry_low       = 4'h2,
        branch_unsigned_not_below = 4'h3,
        branch_unsigned_below     = 4'h4,
        branch_if_negative        = 4'h5,
        branch_if_positive        = 4'h6,
        branch_signed_not_less    = 4'h7,
        branch_signed_less        = 4'h8,
        branch_nibble_carry_high  = 4'h9,
        branch_nibble_carry_low   = 4'hA,
        branch_user_flag_high     = 4'hB
    } cbu_op_t;

    // gray along idle -> taken second cycle -> idle
    typedef enum logic [1:0] {
        CBU_IDLE  = 2'h0,
        CBU_TAKEN = 2'h1
    } cbu_state_t;

    typedef struct packed {
        logic             valid;
        cbu_op_t          op;
        logic [OFS_W-1:0] ofs;
        logic [7:0]       flags;
    } cbu_req_t;

    typedef struct packed {
        cbu_state_t      st;
        logic [PC_W-1:0] pc;
        logic [7:0]      flags;
        logic            busy;
        logic            done;
        logic            taken;
    } cbu_regs_t;

endpackage

// [verilog/cbu_top.sv]
// conditional branch unit: condition test and program counter update
`timescale 1ns/100ps
module cbu_top
(
    // clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst_b,
    // branch request
    input  wire cbu_pkg::cbu_req_t              req,
    // flag word passed on unchanged
    output logic [7:0]                          flags_out,
    // program counter and status
    output logic [cbu_pkg::PC_W-1:0]            pc,
    output logic                                busy,
    output logic                                done,
    output logic                                taken
);

    cbu_pkg::cbu_regs_t       r_q;
    cbu_pkg::cbu_regs_t       r_d;
    logic                     hit;
    logic [cbu_pkg::PC_W-1:0] ofs_ext;
    logic                     accept;

    cbu_cond u_cond
    (
        .op    (req.op),
        .flags (req.flags),
        .hit   (hit)
    );

    // sign extension of the word displacement
    assign ofs_ext = {
        {(cbu_pkg::PC_W-cbu_pkg::OFS_W){req.ofs[cbu_pkg::OFS_W-1]}},
        req.ofs
    };
    assign accept  = req.valid && (r_q.st == cbu_pkg::CBU_IDLE);

    always_comb
    begin
        r_d      = r_q;
        r_d.done = 1'b0;
        r_d.flags = req.flags;
        case (r_q.st)
            cbu_pkg::CBU_IDLE:
            begin
                if (accept)
                begin
                    r_d.pc    = r_q.pc + cbu_pkg::PC_STEP;
                    r_d.taken = hit;
                    if (hit)
                    begin
                        // second cycle for the jump
                        r_d.pc   = r_q.pc + ofs_ext + cbu_pkg::PC_STEP;
                        r_d.st   = cbu_pkg::CBU_TAKEN;
                        r_d.busy = 1'b1;
                    end
                    else
                    begin
                        r_d.done = 1'b1;
                    end
                end
            end
            cbu_pkg::CBU_TAKEN:
            begin
                r_d.st   = cbu_pkg::CBU_IDLE;
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
            end
            default:
            begin
                r_d.st   = cbu_pkg::CBU_IDLE;
                r_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_q <= '{st: cbu_pkg::CBU_IDLE, pc: cbu_pkg::PC_RST,
                     flags: cbu_pkg::FLG_RST, busy: 1'b0, done: 1'b0,
                     taken: 1'b0};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign pc        = r_q.pc;
    assign busy      = r_q.busy;
    assign done      = r_q.done;
    assign taken     = r_q.taken;
    assign flags_out = r_q.flags;

    // assertions
    taken_target_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && hit
        |=> (pc == $past(r_q.pc) + $past(ofs_ext) + cbu_pkg::PC_STEP && busy)
            ##1 (done && !busy))
        else $error("taken branch target or timing wrong");

    fall_through_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && !hit
        |=> pc == $past(r_q.pc) + cbu_pkg::PC_STEP && done && !busy)
        else $error("untaken branch did not step by one");

    not_equal_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_if_not_equal
        |=> taken == !$past(req.flags[cbu_pkg::FLG_Z]))
        else $error("not-equal condition wrong");

    carry_high_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && (req.op == cbu_pkg::branch_on_carry_high
            || req.op == cbu_pkg::branch_unsigned_below)
        |=> taken == $past(req.flags[cbu_pkg::FLG_C]))
        else $error("carry-set condition wrong");

    carry_low_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && (req.op == cbu_pkg::branch_on_carry_low
            || req.op == cbu_pkg::branch_unsigned_not_below)
        |=> taken == !$past(req.flags[cbu_pkg::FLG_C]))
        else $error("carry-clear condition wrong");

    not_below_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_unsigned_not_below
        |=> taken == !$past(req.flags[cbu_pkg::FLG_C]))
        else $error("same-or-higher condition wrong");

    sign_test_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_if_negative
        |=> taken == $past(req.flags[cbu_pkg::FLG_N]))
        else $error("minus condition wrong");

    sign_clear_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_if_positive
        |=> taken == !$past(req.flags[cbu_pkg::FLG_N]))
        else $error("plus condition wrong");

    signed_ge_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_signed_not_less
        |=> taken == !($past(req.flags[cbu_pkg::FLG_N])
            ^ $past(req.flags[cbu_pkg::FLG_V])))
        else $error("signed not-less condition wrong");

    signed_less_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_signed_less
        |=> taken == ($past(req.flags[cbu_pkg::FLG_N])
            ^ $past(req.flags[cbu_pkg::FLG_V])))
        else $error("signed less condition wrong");

    nibble_high_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_nibble_carry_high
        |=> taken == $past(req.flags[cbu_pkg::FLG_H]))
        else $error("nibble carry set condition wrong");

    nibble_low_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_nibble_carry_low
        |=> taken == !$past(req.flags[cbu_pkg::FLG_H]))
        else $error("nibble carry clear condition wrong");

    user_flag_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        accept && req.op == cbu_pkg::branch_user_flag_high
        |=> taken == $past(req.flags[cbu_pkg::FLG_T]))
        else $error("user flag condition wrong");

    flags_kept_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        1'b1 |=> flags_out == $past(req.flags))
        else $error("flag word altered");

    taken_cycle_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        r_q.st == cbu_pkg::CBU_TAKEN
        |=> !busy && done && $stable(pc) && $stable(taken))
        else $error("second cycle of a taken branch wrong");

    idle_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        r_q.st == cbu_pkg::CBU_IDLE && !accept
        |=> $stable(pc) && $stable(taken) && !busy && !done)
        else $error("idle unit changed its outputs");

    busy_taken_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        busy |-> taken && !done)
        else $error("busy outside a taken branch");

    done_idle_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        done |-> !busy && r_q.st == cbu_pkg::CBU_IDLE)
        else $error("done raised while still busy");

endmodule
